//--- include/srw_cfg.svh
// Purpose: timing constants for the supply reset and watchdog block
// Assumes: clk_sys at 25 MHz (40 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

// ============================================================
// clock
`define SRW_CLK_PERIOD_NS 40
`define SRW_NS_PER_MS 1000000

// ============================================================
// supply reset hold delay, 128 us, least time so rounded up
`define SRW_RST_DLY_NS 128000
`define SRW_RST_DLY_CYC \
  ((`SRW_RST_DLY_NS + `SRW_CLK_PERIOD_NS - 1) / `SRW_CLK_PERIOD_NS)

// ============================================================
// watchdog bounds: 1.0 ms least (rounded up), 10 s default (exact)
`define SRW_WD_MIN_MS 1
`define SRW_WD_MIN_CYC \
  ((`SRW_WD_MIN_MS * `SRW_NS_PER_MS + `SRW_CLK_PERIOD_NS - 1) \
   / `SRW_CLK_PERIOD_NS)
`define SRW_WD_DEF_MS 10000
`define SRW_WD_DEF_CYC \
  (`SRW_WD_DEF_MS * (`SRW_NS_PER_MS / `SRW_CLK_PERIOD_NS))

// ============================================================
// reset values
`define SRW_HOST_RST_INIT 1'b0
`define SRW_PROG_INIT 1'b0

`endif

//--- include/srw_pkg.sv
// Purpose: shared types for the supply reset and watchdog block
// Assumes: nothing beyond the cfg header
// Notes: constants live in srw_cfg.svh
package srw_pkg;

  // ============================================================
  // reset sequencer states
  typedef enum logic [1:0] {
    SRW_WAIT_SUPPLY, // supply out of range, reset held low
    SRW_HOLD_DELAY,  // supply good, fixed delay running
    SRW_RUN          // host released
  } srw_state_e;

endpackage : srw_pkg

//--- src/srw_supply_reset_wdog.sv
// Purpose: host reset generator with supply monitor and watchdog
// Assumes: all inputs synchronous to clk_sys; supply comparator is
//          a single already-synchronised good/bad bit
// Notes: long watchdog counts are parameters so tests can shorten them
`timescale 1ns/1ps
`include "srw_cfg.svh"

module srw_supply_reset_wdog #(
  parameter int unsigned RST_DLY_CYC = `SRW_RST_DLY_CYC,
  parameter int unsigned WD_MIN_CYC = `SRW_WD_MIN_CYC,
  parameter int unsigned WD_DEF_CYC = `SRW_WD_DEF_CYC,
  parameter int unsigned WD_W = 28
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic supplySenseIn,
  input wire logic keepalivePulseIn,
  input wire logic watchdogInhibitIn,
  output logic hostResetOutN
);

  // ============================================================
  // local constants
  localparam int unsigned DLY_W = $clog2(RST_DLY_CYC + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RST_DLY_CYC - 1);
  localparam logic [WD_W-1:0] WD_MIN = WD_W'(WD_MIN_CYC);
  localparam logic [WD_W-1:0] WD_DEF = WD_W'(WD_DEF_CYC);

  // ============================================================
  // declarations
  srw_pkg::srw_state_e state;      // sequencer state
  srw_pkg::srw_state_e next_state; // sequencer next state
  logic [DLY_W-1:0] dlyCount;      // cycles spent in hold delay
  logic dlyDone;                   // last cycle of hold delay
  logic kaPrev;                    // keep-alive one cycle ago
  logic kaEdge;                    // any keep-alive edge
  logic kaFall;                    // keep-alive falling edge
  logic [WD_W-1:0] wdCount;        // cycles since last edge
  logic [WD_W-1:0] wdPeriod;       // active timeout in cycles
  logic [WD_W-1:0] pulseWidth;     // width of current high pulse
  logic programmed;                // period taken from a pulse
  logic wdActive;                  // watchdog allowed to run
  logic wdFire;                    // watchdog timeout this cycle
  logic progAccept;                // first pulse width accepted

  // ============================================================
  // reset sequencer
  assign dlyDone = (dlyCount == DLY_LAST);

  // next state: supply loss always wins over the watchdog
  always_comb begin
    next_state = state;
    case (state)
      srw_pkg::SRW_WAIT_SUPPLY: begin
        if (supplySenseIn) begin
          next_state = srw_pkg::SRW_HOLD_DELAY;
        end
      end
      srw_pkg::SRW_HOLD_DELAY: begin
        if (!supplySenseIn) begin
          next_state = srw_pkg::SRW_WAIT_SUPPLY;
        end else if (dlyDone) begin
          next_state = srw_pkg::SRW_RUN;
        end
      end
      srw_pkg::SRW_RUN: begin
        if (!supplySenseIn) begin
          next_state = srw_pkg::SRW_WAIT_SUPPLY;
        end else if (wdFire) begin
          next_state = srw_pkg::SRW_HOLD_DELAY;
        end
      end
      default: begin
        next_state = srw_pkg::SRW_WAIT_SUPPLY;
      end
    endcase
  end

  // state register: reset parks in wait so the output starts low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= srw_pkg::SRW_WAIT_SUPPLY;
    end else begin
      state <= next_state;
    end
  end

  // hold delay counter, counts clock cycles only in hold delay and holds at the last
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state != srw_pkg::SRW_HOLD_DELAY) begin
      dlyCount <= '0;
    end else if (!dlyDone) begin
      dlyCount <= dlyCount + 1'b1;
    end
  end

  // reset output from a flop so it never glitches toward the host
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hostResetOutN <= `SRW_HOST_RST_INIT;
    end else begin
      hostResetOutN <= (next_state == srw_pkg::SRW_RUN);
    end
  end

  // ============================================================
  // keep-alive edge detection
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      kaPrev <= 1'b0;
    end else begin
      kaPrev <= keepalivePulseIn;
    end
  end

  assign kaEdge = keepalivePulseIn ^ kaPrev;
  assign kaFall = kaPrev & ~keepalivePulseIn;

  // ============================================================
  // watchdog timer
  // counting only while the host runs; inhibit also clears the count
  // so that releasing inhibit grants a full period
  assign wdActive = (state == srw_pkg::SRW_RUN) && !watchdogInhibitIn;
  assign wdFire = wdActive && !kaEdge && (wdCount >= wdPeriod - 1'b1);

  // cycles since the most recent keep-alive edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !wdActive || kaEdge) begin
      wdCount <= '0;
    end else if (!wdFire) begin
      wdCount <= wdCount + 1'b1;
    end
  end

  // high-time of the keep-alive, saturating at the default
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !keepalivePulseIn) begin
      pulseWidth <= '0;
    end else if (pulseWidth < WD_DEF) begin
      pulseWidth <= pulseWidth + 1'b1;
    end
  end

  // only the first in-bounds pulse after release programs; width must lie
  // strictly between the bounds, otherwise it is just a refresh
  assign progAccept = kaFall && !programmed
                      && (state == srw_pkg::SRW_RUN)
                      && (pulseWidth > WD_MIN) && (pulseWidth < WD_DEF);

  // period register: default after any host reset, including ours
  always_ff @(posedge clk_sys) begin
    if (sys_rst || wdFire || state != srw_pkg::SRW_RUN) begin
      wdPeriod <= WD_DEF;
      programmed <= `SRW_PROG_INIT;
    end else if (progAccept) begin
      wdPeriod <= pulseWidth;
      programmed <= 1'b1;
    end
  end

  // ============================================================
  // assertions
  property p_rel_needs_supply;
    @(posedge clk_sys) disable iff (sys_rst)
    hostResetOutN |-> $past(supplySenseIn);
  endproperty
  a_rel_needs_supply: assert property (p_rel_needs_supply)
    else $error("reset released without good supply");

  property p_rel_after_delay;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(hostResetOutN) |-> $past(dlyCount) == DLY_LAST;
  endproperty
  a_rel_after_delay: assert property (p_rel_after_delay)
    else $error("reset released before hold delay ended");

  property p_supply_bad_low;
    @(posedge clk_sys) disable iff (sys_rst)
    !supplySenseIn |=> !hostResetOutN;
  endproperty
  a_supply_bad_low: assert property (p_supply_bad_low)
    else $error("reset high while supply bad");

  property p_period_bounds;
    @(posedge clk_sys) disable iff (sys_rst)
    wdPeriod > WD_MIN && wdPeriod <= WD_DEF;
  endproperty
  a_period_bounds: assert property (p_period_bounds)
    else $error("watchdog period out of bounds");

  property p_fire_resets;
    @(posedge clk_sys) disable iff (sys_rst)
    wdFire && supplySenseIn |=> !hostResetOutN;
  endproperty
  a_fire_resets: assert property (p_fire_resets)
    else $error("watchdog timeout did not reset host");

  property p_prog_width;
    @(posedge clk_sys) disable iff (sys_rst)
    progAccept |=> programmed && wdPeriod == $past(pulseWidth);
  endproperty
  a_prog_width: assert property (p_prog_width)
    else $error("programmed period differs from pulse width");

  property p_reload_default;
    @(posedge clk_sys) disable iff (sys_rst)
    wdFire |=> wdPeriod == WD_DEF && !programmed;
  endproperty
  a_reload_default: assert property (p_reload_default)
    else $error("default period not reloaded after timeout");

  property p_inhibit;
    @(posedge clk_sys) disable iff (sys_rst)
    watchdogInhibitIn && supplySenseIn && hostResetOutN |=> hostResetOutN;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("watchdog fired while inhibited");

  property p_edge_restart;
    @(posedge clk_sys) disable iff (sys_rst)
    kaEdge |=> wdCount == '0;
  endproperty
  a_edge_restart: assert property (p_edge_restart)
    else $error("keep-alive edge did not restart count");

  property p_wd_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    wdFire |=> !hostResetOutN [*8];
  endproperty
  a_wd_hold: assert property (p_wd_hold)
    else $error("watchdog reset pulse too short");

  property p_dly_step;
    @(posedge clk_sys) disable iff (sys_rst)
    state == srw_pkg::SRW_HOLD_DELAY && !dlyDone && supplySenseIn
      |=> dlyCount == $past(dlyCount) + 1'b1;
  endproperty
  a_dly_step: assert property (p_dly_step)
    else $error("hold delay counter did not advance");

  // main scenarios
  c_release: cover property (@(posedge clk_sys) $rose(hostResetOutN));
  c_wd_fire: cover property (@(posedge clk_sys) wdFire);
  c_prog: cover property (@(posedge clk_sys) progAccept);
  c_dropout: cover property (@(posedge clk_sys)
    hostResetOutN && !supplySenseIn);

endmodule : srw_supply_reset_wdog

//--- test/srw_host_model.sv
// Purpose: host side model, drives the keep-alive pin
// Assumes: host changes its pin just after a falling clk_sys edge
// Notes: pin holds still between calls, as a stalled loop would
`timescale 1ns/1ps
module srw_host_model (
  input wire logic clk_sys,
  input wire logic hostResetOutN,
  output logic keepalivePulseIn
);
  // ============================================================
  // keep-alive driver
  initial keepalivePulseIn = 1'b0; // idle low until the host acts
  // programming pulse, high for w cycles; width sets the period
  task automatic pulse(input int w);
    @(negedge clk_sys);
    keepalivePulseIn = 1'b1;
    repeat (w) @(negedge clk_sys);
    keepalivePulseIn = 1'b0;
  endtask : pulse
  // one refresh edge per main loop pass, never from a timer
  task automatic pet();
    @(negedge clk_sys);
    keepalivePulseIn = ~keepalivePulseIn;
  endtask : pet
  // ============================================================
  // reset monitor: counts falls of the reset line seen by the host
  int resetsSeen = 0; // host resets observed since power-up
  logic prevOut = 1'b0; // reset line at the previous edge
  always @(posedge clk_sys) begin
    if (prevOut === 1'b1 && hostResetOutN === 1'b0) begin
      resetsSeen <= resetsSeen + 1;
    end
    prevOut <= hostResetOutN;
  end
endmodule : srw_host_model

//--- test/srw_supply_reset_wdog_tb_top.sv
// Purpose: self-checking bench for the supply reset and watchdog
// Assumes: shortened counts, inputs driven at falling edges
// Notes: watchdog times checked within one cycle either way
`timescale 1ns/1ps
module srw_supply_reset_wdog_tb_top;
  localparam int unsigned RST = 8; // shortened hold delay
  localparam int unsigned DEF = 200; // shortened default period
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic supplySenseIn = 1'b0;
  logic watchdogInhibitIn = 1'b0;
  logic keepalivePulseIn;
  logic hostResetOutN;
  int n_fail = 0;
  int check_count = 0;
  int n; // falling edges counted by waitOut
  // ============================================================
  // clock, design and host
  initial forever #20 clk_sys = ~clk_sys;
  srw_supply_reset_wdog #(.RST_DLY_CYC(RST), .WD_MIN_CYC(4),
    .WD_DEF_CYC(DEF)) srw_supply_reset_wdog_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .supplySenseIn(supplySenseIn),
    .keepalivePulseIn(keepalivePulseIn),
    .watchdogInhibitIn(watchdogInhibitIn),
    .hostResetOutN(hostResetOutN));
  srw_host_model srw_host_model_inst (.clk_sys(clk_sys),
    .hostResetOutN(hostResetOutN),
    .keepalivePulseIn(keepalivePulseIn));
  // ============================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  // counts falling edges until the reset output reaches lvl
  task automatic waitOut(input logic lvl, input int lim);
    n = 0;
    while (hostResetOutN !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : waitOut
  // one cycle of slack: the exact start edge is a design choice
  task automatic near(input string what, input int e);
    chk(what, (n + 1 >= e && n <= e + 1) ? e : n, e);
  endtask : near
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // ============================================================
  // scenarios
  task automatic powerUp();
    repeat (12) @(negedge clk_sys);
    chk("out in reset", hostResetOutN, 1'b0);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    chk("out after reset", hostResetOutN, 1'b0);
    supplySenseIn = 1'b1;
    waitOut(1'b1, 50);
    chk("power-up delay", n, RST + 1);
  endtask : powerUp
  // supply dip with inhibit set still resets; inhibit then holds
  task automatic dipInhibited();
    @(negedge clk_sys);
    supplySenseIn = 1'b0;
    watchdogInhibitIn = 1'b1;
    @(negedge clk_sys);
    chk("out on dip", hostResetOutN, 1'b0);
    repeat (3) @(negedge clk_sys);
    supplySenseIn = 1'b1;
    waitOut(1'b1, 50);
    chk("dip delay", n, RST + 1);
    repeat (DEF + 50) @(negedge clk_sys);
    chk("inhibited", hostResetOutN, 1'b1);
    watchdogInhibitIn = 1'b0;
    waitOut(1'b0, DEF + 10);
    near("default period", DEF);
    waitOut(1'b1, 50);
    chk("wd pulse length", n, RST);
  endtask : dipInhibited
  // programmed period, then default again after the reset
  task automatic programmed();
    srw_host_model_inst.pulse(20);
    waitOut(1'b0, DEF);
    near("programmed period", 20);
    waitOut(1'b1, 50);
    waitOut(1'b0, DEF + 10);
    near("reloaded default", DEF);
  endtask : programmed
  // refreshes inside the period keep the host running
  task automatic refreshed();
    waitOut(1'b1, 50);
    srw_host_model_inst.pulse(20);
    repeat (8) begin
      repeat (15) @(negedge clk_sys);
      srw_host_model_inst.pet();
    end
    chk("refreshed", hostResetOutN, 1'b1);
    waitOut(1'b0, 40);
    near("missed refresh", 20);
  endtask : refreshed
  // width equal to the minimum is not taken as a period
  task automatic boundary();
    waitOut(1'b1, 50);
    srw_host_model_inst.pulse(4);
    waitOut(1'b0, DEF + 10);
    near("minimum width ignored", DEF);
    @(negedge clk_sys);
    chk("host resets seen", srw_host_model_inst.resetsSeen, 6);
  endtask : boundary
  initial begin
    powerUp();
    dipInhibited();
    programmed();
    refreshed();
    boundary();
    summarize();
  end
  // hang guard, well beyond the roughly 1130 cycles needed
  initial begin
    #(40 * 5000);
    n_fail++;
    summarize();
  end
endmodule : srw_supply_reset_wdog_tb_top
